// >>> rtl/conv_host.sv
`include "conv_cfg.svh"
module conv_host #(
   parameter int NUM_CH = `NUM_CHANNELS
) (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // software port
   input wire logic [1:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   // link to device
   conv_link_if.host link
);
   initial begin
      if (NUM_CH != `NUM_CHANNELS) begin
         $error("conv_host: unsupported channel count");
      end
   end
   localparam int W = `RESULT_WIDTH;
   // synchronise device outputs
   logic [1:0] busy_pipe;
   logic [W-1:0] data_meta;
   logic [W-1:0] data_sync;
   logic [1:0] flag_pipe;
   always_ff @(posedge clk) begin
      if (srst) begin
         busy_pipe <= 2'b00;
         flag_pipe <= 2'b00;
         data_meta <= 16'h0000;
         data_sync <= 16'h0000;
      end else begin
         busy_pipe <= {busy_pipe[0], link.busy};
         flag_pipe <= {flag_pipe[0], link.first_channel_flag};
         data_meta <= link.parallel_result_bus;
         data_sync <= data_meta;
      end
   end
   wire busy_s = busy_pipe[1];
   // control register
   logic split;
   logic separate;
   logic hold_cs;
   logic start_req;
   logic [7:0] skip_mask;
   logic [W-1:0] results [NUM_CH];
   logic [7:0] first_seen;
   logic frame_done;
   conv_pkg::host_state_t state;
   logic [3:0] phase;
   logic [$clog2(NUM_CH+1)-1:0] ch_cnt;
   wire wr_ctrl = wr && addr == `REG_CTRL;
   always_ff @(posedge clk) begin
      if (srst) begin
         split <= 1'b0;
         separate <= 1'b0;
         hold_cs <= 1'b0;
         skip_mask <= 8'h00;
      end else begin
         if (wr_ctrl) begin
            split <= wdata[`CTRL_SPLIT];
            separate <= wdata[`CTRL_SEPARATE];
            hold_cs <= wdata[`CTRL_HOLD_CS];
         end
         if (wr && addr == `REG_SKIP) begin
            skip_mask <= wdata[7:0];
         end
      end
   end
   // the sequencer waits a fixed settle time per strobe to cover two sync stages each end
   wire step = (phase == 4'h7);
   always_ff @(posedge clk) begin
      if (srst) begin
         state <= conv_pkg::host_idle;
         phase <= 4'h0;
         ch_cnt <= '0;
         start_req <= 1'b0;
         frame_done <= 1'b0;
         first_seen <= 8'h00;
      end else begin
         phase <= (state == conv_pkg::host_idle || step) ? 4'h0 : phase + 4'h1;
         if (wr_ctrl && wdata[`CTRL_START] && state == conv_pkg::host_idle) begin
            start_req <= 1'b1;
            state <= conv_pkg::host_start;
            frame_done <= 1'b0;
         end
         unique case (state)
            conv_pkg::host_idle: begin
            end
            conv_pkg::host_start: begin
               if (step) begin
                  start_req <= 1'b0;
                  state <= conv_pkg::host_wait_busy;
               end
            end
            conv_pkg::host_wait_busy: begin
               if (step && !busy_s) begin
                  state <= conv_pkg::host_rd_low;
                  ch_cnt <= '0;
               end
            end
            conv_pkg::host_rd_low: begin
               if (step) begin
                  results[ch_cnt[2:0]] <= data_sync;
                  first_seen[ch_cnt[2:0]] <= flag_pipe[1];
                  state <= conv_pkg::host_rd_high;
                  ch_cnt <= ch_cnt + 1'b1;
               end
            end
            conv_pkg::host_rd_high: begin
               if (step) begin
                  state <= (ch_cnt == NUM_CH) ? conv_pkg::host_done : conv_pkg::host_rd_low;
               end
            end
            conv_pkg::host_done: begin
               if (step) begin
                  frame_done <= 1'b1;
                  state <= conv_pkg::host_idle;
               end
            end
         endcase
      end
   end
   // group b start trails by half the start phase in split mode
   wire start_b = split ? (start_req && phase >= 4'h4) : start_req;
   assign link.group_a_conv_start = start_req;
   assign link.group_b_conv_start = start_b;
   wire reading = (state == conv_pkg::host_rd_low);
   wire in_frame = reading || state == conv_pkg::host_rd_high;
   assign link.rd_n = ~reading;
   assign link.cs_n = hold_cs ? 1'b0 : (separate ? ~in_frame : ~reading);
   assign link.primary_iface_select = 1'b0;
   assign link.secondary_iface_select = 1'b0;
   // read back
   wire [31:0] status_word = {22'h00_0000, first_seen, busy_s, frame_done};
   always_ff @(posedge clk) begin
      if (srst) begin
         rdata <= 32'h0000_0000;
      end else if (rd) begin
         unique case (addr)
            `REG_CTRL: rdata <= {28'h000_0000, hold_cs, separate, split, 1'b0};
            `REG_STATUS: rdata <= status_word;
            `REG_DATA: rdata <= {16'h0000, results[wdata[2:0]]};
            `REG_SKIP: rdata <= {24'h00_0000, skip_mask};
         endcase
      end else begin
         rdata <= 32'h0000_0000;
      end
   end
endmodule : conv_host

// >>> rtl/conv_cfg.svh
`ifndef CONV_CFG_SVH
`define CONV_CFG_SVH
`define NUM_CHANNELS 8
`define RESULT_WIDTH 16
`define GROUP_A_LAST 3
`define CONV_TIME_NS 4000
`define CLK_PERIOD_NS 40
`define CONV_CYCLES ((`CONV_TIME_NS) / (`CLK_PERIOD_NS))
`define CTRL_START 0
`define CTRL_SPLIT 1
`define CTRL_SEPARATE 2
`define CTRL_HOLD_CS 3
`define REG_CTRL 2'h0
`define REG_STATUS 2'h1
`define REG_DATA 2'h2
`define REG_SKIP 2'h3
`endif

// >>> rtl/conv_pkg.sv
package conv_pkg;
   typedef enum logic [1:0] {
      iface_parallel,
      iface_byte,
      iface_serial
   } iface_mode_t;
   typedef enum logic [1:0] {
      dev_idle,
      dev_wait_pair,
      dev_convert
   } dev_state_t;
   typedef enum logic [2:0] {
      host_idle,
      host_start,
      host_wait_busy,
      host_rd_low,
      host_rd_high,
      host_done
   } host_state_t;
endpackage : conv_pkg

// >>> rtl/conv_link_if.sv
interface conv_link_if;
   logic group_a_conv_start;
   logic group_b_conv_start;
   logic cs_n;
   logic rd_n;
   logic primary_iface_select;
   logic busy;
   logic [15:0] parallel_result_bus;
   logic bus_oe_n;
   logic first_channel_flag;
   logic flag_oe_n;
   logic secondary_iface_select;
   modport device (
      input group_a_conv_start, group_b_conv_start, cs_n, rd_n,
      input primary_iface_select, secondary_iface_select,
      output busy, parallel_result_bus, bus_oe_n, first_channel_flag, flag_oe_n
   );
   modport host (
      output group_a_conv_start, group_b_conv_start, cs_n, rd_n,
      output primary_iface_select, secondary_iface_select,
      input busy, parallel_result_bus, bus_oe_n, first_channel_flag, flag_oe_n
   );
endinterface : conv_link_if

// >>> rtl/conv_device.sv
`include "conv_cfg.svh"
module conv_device #(
   parameter int NUM_CH = `NUM_CHANNELS,
   parameter int CONV_CYCLES = `CONV_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // link to host
   conv_link_if.device link,
   // sampled analog values, channel 1 in the low word
   input wire logic [`NUM_CHANNELS*`RESULT_WIDTH-1:0] analog_sample
);
   initial begin
      if (NUM_CH != `NUM_CHANNELS || CONV_CYCLES < 1) begin
         $error("conv_device: unsupported parameters");
      end
   end
   localparam int W = `RESULT_WIDTH;
   // two-flop synchronisers for every pin input
   logic [5:0] pin_meta;
   logic [5:0] pin_sync;
   logic [5:0] pin_prev;
   wire [5:0] pin_raw = {link.secondary_iface_select, link.primary_iface_select,
                         link.rd_n, link.cs_n, link.group_b_conv_start,
                         link.group_a_conv_start};
   always_ff @(posedge clk) begin
      if (srst) begin
         pin_meta <= 6'h0F;
         pin_sync <= 6'h0F;
         pin_prev <= 6'h0F;
      end else begin
         pin_meta <= pin_raw;
         pin_sync <= pin_meta;
         pin_prev <= pin_sync;
      end
   end
   wire a_rise = pin_sync[0] & ~pin_prev[0];
   wire b_rise = pin_sync[1] & ~pin_prev[1];
   wire cs_n_s = pin_sync[2];
   wire rd_n_s = pin_sync[3];
   wire rd_fall = ~rd_n_s & pin_prev[3];
   wire cs_rise = cs_n_s & ~pin_prev[2];
   conv_pkg::iface_mode_t mode;
   assign mode = !pin_sync[4] ? conv_pkg::iface_parallel :
                 (pin_sync[5] ? conv_pkg::iface_byte : conv_pkg::iface_serial);
   wire parallel_mode = (mode == conv_pkg::iface_parallel);
   // sampling and conversion
   conv_pkg::dev_state_t state;
   logic a_held;
   logic b_held;
   logic [W-1:0] hold [NUM_CH];
   logic [W-1:0] result [NUM_CH];
   logic [$clog2(CONV_CYCLES+1)-1:0] conv_cnt;
   wire a_now = a_held | a_rise;
   wire b_now = b_held | b_rise;
   wire both_held = a_now & b_now;
   wire conv_done = (state == conv_pkg::dev_convert) && (conv_cnt == 1);
   always_ff @(posedge clk) begin
      if (srst) begin
         state <= conv_pkg::dev_idle;
         a_held <= 1'b0;
         b_held <= 1'b0;
         conv_cnt <= '0;
      end else begin
         unique case (state)
            conv_pkg::dev_idle, conv_pkg::dev_wait_pair: begin
               a_held <= a_now;
               b_held <= b_now;
               if (both_held) begin
                  state <= conv_pkg::dev_convert;
                  conv_cnt <= CONV_CYCLES[$bits(conv_cnt)-1:0];
               end else if (a_now | b_now) begin
                  state <= conv_pkg::dev_wait_pair;
               end
            end
            conv_pkg::dev_convert: begin
               a_held <= 1'b0;
               b_held <= 1'b0;
               conv_cnt <= conv_cnt - 1'b1;
               if (conv_done) begin
                  state <= conv_pkg::dev_idle;
               end
            end
         endcase
      end
   end
   // hold stage per group; results move only when busy falls
   genvar ch;
   generate
      for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
         wire grp_edge = (ch <= `GROUP_A_LAST) ? a_rise : b_rise;
         wire grp_held = (ch <= `GROUP_A_LAST) ? a_held : b_held;
         always_ff @(posedge clk) begin
            if (srst) begin
               hold[ch] <= 16'h0000;
               result[ch] <= 16'h0000;
            end else begin
               if (grp_edge && !grp_held && state != conv_pkg::dev_convert) begin
                  hold[ch] <= analog_sample[ch*W +: W];
               end
               if (conv_done) begin
                  result[ch] <= hold[ch];
               end
            end
         end
      end
   endgenerate
   assign link.busy = (state == conv_pkg::dev_convert);
   // parallel readout
   logic [$clog2(NUM_CH+1)-1:0] rd_ptr;
   logic [W-1:0] out_word;
   logic out_first;
   logic out_active;
   // with strobes tied, chip select rises between every word, so only a new
   // conversion restarts the pointer; a chip select rise just releases the bus
   wire frame_reset = conv_done;
   wire read_step = rd_fall & ~cs_n_s & parallel_mode;
   always_ff @(posedge clk) begin
      if (srst) begin
         rd_ptr <= '0;
         out_word <= 16'h0000;
         out_first <= 1'b0;
         out_active <= 1'b0;
      end else if (frame_reset) begin
         rd_ptr <= '0;
         out_first <= 1'b0;
         out_active <= 1'b0;
      end else if (cs_rise) begin
         out_active <= 1'b0;
      end else if (read_step) begin
         if (rd_ptr < NUM_CH) begin
            out_word <= result[rd_ptr[$clog2(NUM_CH)-1:0]];
            out_first <= (rd_ptr == 0);
            rd_ptr <= rd_ptr + 1'b1;
         end else begin
            out_first <= 1'b0;
         end
         out_active <= 1'b1;
      end
   end
   // bus driven only while both strobes are low in parallel mode; flag driven after a read until chip select rises or a conversion ends
   wire drive = out_active & parallel_mode & ~cs_n_s & ~rd_n_s;
   assign link.parallel_result_bus = out_word;
   assign link.first_channel_flag = out_first;
   assign link.bus_oe_n = ~drive;
   assign link.flag_oe_n = ~(out_active & ~cs_n_s);
endmodule : conv_device

// >>> verification/conv_link_properties.sv
module conv_link_properties #(
   parameter int CONV_CYCLES = 100
) (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // host strobes
   input wire logic group_a_conv_start,
   input wire logic group_b_conv_start,
   input wire logic cs_n,
   input wire logic rd_n,
   // device answers
   input wire logic busy,
   input wire logic bus_oe_n,
   input wire logic first_channel_flag,
   input wire logic flag_oe_n
);
   logic [15:0] busy_cnt;
   logic [3:0] rd_cnt;
   logic rd_q;
   logic busy_q;
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   // read count restarts at end of conversion, so it names the channel on the bus
   always_ff @(posedge clk) begin
      if (srst) begin
         busy_cnt <= '0;
         rd_cnt <= '0;
         rd_q <= 1'b1;
         busy_q <= 1'b0;
      end else begin
         rd_q <= rd_n;
         busy_q <= busy;
         busy_cnt <= busy ? busy_cnt + 16'h0001 : 16'h0000;
         if (busy_q && !busy) begin
            rd_cnt <= 4'h0;
         end else if (rd_q && !rd_n && rd_cnt != 4'hf) begin
            rd_cnt <= rd_cnt + 4'h1;
         end
      end
   end
   start_busy_a: assert property (
      $rose(group_b_conv_start) && group_a_conv_start && !busy |-> ##[1:6] busy)
      else $error("busy did not follow the start pair");
   wait_pair_a: assert property (
      $rose(group_a_conv_start) && !group_b_conv_start && !busy |=> !busy [*4])
      else $error("busy rose on one group edge");
   busy_max_a: assert property (busy |-> busy_cnt < CONV_CYCLES)
      else $error("busy outlasted the conversion time");
   bus_tri_a: assert property (rd_n [*4] |-> bus_oe_n)
      else $error("bus driven with read strobe high");
   flag_tri_a: assert property (cs_n [*4] |-> flag_oe_n)
      else $error("flag driven with chip select high");
   bus_on_a: assert property ((!cs_n && !rd_n) [*4] |-> !bus_oe_n)
      else $error("bus not driven during read");
   first_flag_a: assert property (
      (!rd_n) [*5] |-> !flag_oe_n && first_channel_flag == (rd_cnt == 4'h1))
      else $error("first channel flag wrong");
   read_shape_a: assert property ($fell(rd_n) |=> (!rd_n) [*7] ##1 rd_n)
      else $error("read strobe not eight cycles low");
   frame_len_a: assert property ($rose(busy) |-> rd_cnt == 4'h0 || rd_cnt == 4'h8)
      else $error("frame did not read every channel");
   cover property ($fell(busy));
   cover property ($rose(first_channel_flag));
   cover property ($rose(group_a_conv_start) && !group_b_conv_start);
endmodule : conv_link_properties

// >>> verification/sampling_conversion_parallel_readout_bench.sv
module sampling_conversion_parallel_readout_bench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int CONV = 20;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [1:0] addr = 2'h0;
   logic [31:0] wdata = 32'h0000_0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [31:0] rdata;
   logic [127:0] analog_sample = '0;
   int err_count = 0;
   int checks_done = 0;
   conv_link_if conv_link_if_i ();
   conv_device #(.CONV_CYCLES(CONV)) conv_device_i (.clk(clk), .srst(srst),
      .link(conv_link_if_i), .analog_sample(analog_sample));
   conv_host conv_host_i (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .link(conv_link_if_i));
   conv_link_properties #(.CONV_CYCLES(CONV)) conv_link_properties_i (.clk(clk),
      .srst(srst), .group_a_conv_start(conv_link_if_i.group_a_conv_start),
      .group_b_conv_start(conv_link_if_i.group_b_conv_start), .cs_n(conv_link_if_i.cs_n),
      .rd_n(conv_link_if_i.rd_n), .busy(conv_link_if_i.busy),
      .bus_oe_n(conv_link_if_i.bus_oe_n), .flag_oe_n(conv_link_if_i.flag_oe_n),
      .first_channel_flag(conv_link_if_i.first_channel_flag));
   initial begin
      forever #20 clk = ~clk;
   end
   task automatic tally_and_finish();
      if (err_count == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : tally_and_finish
   task automatic check_word(input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         $display("mismatch at %0t: expected %h, got %h", $time, exp, got);
         err_count++;
      end
   endtask : check_word
   task automatic guard(input bit ok);
      if (!ok) begin
         err_count++;
         tally_and_finish();
      end
   endtask : guard
   task automatic wr_reg(input logic [1:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [1:0] a, input logic [2:0] idx, output logic [31:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= {29'h0000_0000, idx};
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      v = rdata;
   endtask : rd_reg
   task automatic run_frame(input logic [31:0] ctrl, input logic [3:0] k);
      logic [15:0] exp [8];
      logic [31:0] v;
      int n;
      @(posedge clk);
      for (int i = 0; i < 8; i++) begin
         exp[i] = {k, i[3:0], ~k, ~i[3:0]};
         analog_sample[16*i +: 16] <= exp[i];
      end
      wr_reg(2'h0, ctrl);
      n = 0;
      while (conv_link_if_i.busy !== 1'b1 && n < 60) begin
         @(posedge clk);
         n++;
      end
      guard(n < 60);
      // inputs move once held: results must still show the captured values
      @(posedge clk);
      analog_sample <= ~analog_sample;
      n = 0;
      do begin
         rd_reg(2'h1, 3'h0, v);
         n++;
      end while (v[0] !== 1'b1 && n < 500);
      guard(n < 500);
      check_word(32'h0000_0005, v);
      for (int i = 0; i < 8; i++) begin
         rd_reg(2'h2, i[2:0], v);
         check_word({16'h0000, exp[i]}, v);
      end
   endtask : run_frame
   task automatic reset_state();
      logic [31:0] v;
      rd_reg(2'h1, 3'h0, v);
      check_word(32'h0000_0000, v);
      check_word(32'h0000_0003, {29'h0000_0000, conv_link_if_i.busy,
         conv_link_if_i.bus_oe_n, conv_link_if_i.flag_oe_n});
      wr_reg(2'h3, 32'h0000_00a5);
      rd_reg(2'h3, 3'h0, v);
      check_word(32'h0000_00a5, v);
   endtask : reset_state
   task automatic common_start();
      run_frame(32'h0000_0001, 4'h3);
   endtask : common_start
   task automatic split_start();
      run_frame(32'h0000_0003, 4'h6);
   endtask : split_start
   task automatic separate_strobes();
      run_frame(32'h0000_0005, 4'h9);
   endtask : separate_strobes
   task automatic held_select();
      run_frame(32'h0000_0009, 4'hc);
   endtask : held_select
   initial begin
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      reset_state();
      common_start();
      split_start();
      separate_strobes();
      held_select();
      tally_and_finish();
   end
endmodule : sampling_conversion_parallel_readout_bench
